// ---- src/aarc_consts.vh ----
`ifndef AARC_CONSTS_VH
`define AARC_CONSTS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define AARC_ADDR_W        8
`define AARC_DATA_W        16
`define AARC_OFS_AUX4      8'h9b
`define AARC_OFS_USB       8'h9c
`define AARC_OFS_LINE      8'h9d
`define AARC_OFS_BATT      8'h9e
`define AARC_OFS_TEMP      8'h9f
`define AARC_OFS_CMP_EN    8'ha3
`define AARC_OFS_CMP1      8'ha4
`define AARC_OFS_IRQ_STAT  8'hb0
`define AARC_OFS_IRQ_CLR   8'hb1
`define AARC_OFS_IRQ_EN    8'hb2

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define AARC_RES_W         12
`define AARC_RES_MSB       11
`define AARC_RES_LSB       0
`define AARC_SCALE_MSB     14
`define AARC_SCALE_LSB     13
`define AARC_REF_BIT       12
`define AARC_SRC_MSB       15
`define AARC_SRC_LSB       13
`define AARC_ABOVE_BIT     12
`define AARC_NUM_CMP       4
`define AARC_CMP1_BIT      0

// ----------------------------------------------------------------
// source codes
// ----------------------------------------------------------------
`define AARC_SRC_AUX4      3'h3
`define AARC_SRC_USB       3'h4
`define AARC_SRC_LINE      3'h5
`define AARC_SRC_BATT      3'h6
`define AARC_SRC_TEMP      3'h7

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AARC_RST_SCALE     2'h3
`define AARC_RST_REF       1'h1
`define AARC_RST_RES       12'h000
`define AARC_RST_EN        4'h0
`define AARC_RST_SRC       3'h0
`define AARC_RST_ABOVE     1'h0
`define AARC_RST_WORD      16'h0000

`endif

// ---- src/aarc_cmp.v ----
`timescale 1ns/1ps
`default_nettype none
`include "aarc_consts.vh"

module aarc_cmp #(
   parameter RES_W = `AARC_RES_W
) (
   input  wire             enable_in,    // comparator enable
   input  wire [2:0]       source_in,    // selected source code
   input  wire             above_in,     // 1 flags above threshold
   input  wire [RES_W-1:0] threshold_in, // unsigned threshold
   input  wire             res_valid_in, // new result strobe
   input  wire [2:0]       res_src_in,   // source of new result
   input  wire [RES_W-1:0] res_data_in,  // new result value
   output wire             hit_out       // qualifying result, pulse
);

   // ----------------------------------------------------------------
   // threshold compare
   // ----------------------------------------------------------------
   wire is_above;
   wire is_below;
   wire match;

   // direct unsigned compare against the threshold
   assign is_above = (res_data_in > threshold_in);
   assign is_below = (res_data_in < threshold_in);
   // only a new result of the selected source counts
   assign match    = res_valid_in & (res_src_in == source_in);
   // direction select, disabled raises nothing
   assign hit_out  = enable_in & match &
                     (above_in ? is_above : is_below);

endmodule // aarc_cmp
`default_nettype wire

// ---- src/aarc_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "aarc_consts.vh"

module aarc_top #(
   parameter ADDR_W = `AARC_ADDR_W,
   parameter DATA_W = `AARC_DATA_W,
   parameter RES_W  = `AARC_RES_W,
   parameter NCMP   = `AARC_NUM_CMP
) (
   input  wire              ref_clk_in,            // 40 mhz clock
   input  wire              rst_n_in,              // async reset, low
   input  wire [ADDR_W-1:0] addr_in,               // register address
   input  wire [DATA_W-1:0] wr_data_in,            // write data
   input  wire              wr_en_in,              // write strobe
   input  wire              rd_en_in,              // read strobe
   output reg  [DATA_W-1:0] rd_data_out,           // read data, next cycle
   input  wire              res_valid_in,          // converter result strobe
   input  wire [2:0]        res_src_in,            // converter result source
   input  wire [RES_W-1:0]  res_data_in,           // converter result value
   output reg  [1:0]        input4_scale_sel_out,  // input 4 scaling
   output reg               input4_reference_sel_out, // input 4 reference
   output reg  [NCMP-1:0]   cmp_enables_out,       // comparator enables
   output reg               irq_out                // level interrupt
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   reg [1:0]       scale_ff;
   reg             ref_ff;
   reg [RES_W-1:0] input4_result_ff;
   reg [RES_W-1:0] usb_supply_result_ff;
   reg [RES_W-1:0] adaptor_supply_result_ff;
   reg [RES_W-1:0] battery_result_ff;
   reg [RES_W-1:0] die_temp_result_ff;
   reg [NCMP-1:0]  cmp_en_ff;
   reg [2:0]       cmp_one_source_ff;
   reg             cmp_one_above_mode_ff;
   reg [RES_W-1:0] cmp_one_threshold_ff;
   reg [NCMP-1:0]  irq_stat_ff;
   reg [NCMP-1:0]  irq_en_ff;

   reg [NCMP-1:0]   nxt_irq_stat;
   reg [NCMP-1:0]   nxt_irq_en;
   reg [DATA_W-1:0] nxt_rd_data;
   reg [NCMP-1:0]   evt;
   reg [NCMP-1:0]   clr;

   wire cmp_one_hit;

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   wire wr_aux4   = wr_en_in & (addr_in == `AARC_OFS_AUX4);
   wire wr_cmp_en = wr_en_in & (addr_in == `AARC_OFS_CMP_EN);
   wire wr_cmp1   = wr_en_in & (addr_in == `AARC_OFS_CMP1);
   wire wr_clr    = wr_en_in & (addr_in == `AARC_OFS_IRQ_CLR);
   wire wr_irq_en = wr_en_in & (addr_in == `AARC_OFS_IRQ_EN);

   // ----------------------------------------------------------------
   // input 4 setup
   // ----------------------------------------------------------------
   // scale and reference are the writable part of the input 4 word
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scale_ff <= `AARC_RST_SCALE;
         ref_ff   <= `AARC_RST_REF;
      end else if (wr_aux4) begin
         scale_ff <= wr_data_in[`AARC_SCALE_MSB:`AARC_SCALE_LSB];
         ref_ff   <= wr_data_in[`AARC_REF_BIT];
      end
   end

   // ----------------------------------------------------------------
   // result capture
   // ----------------------------------------------------------------
   // each result of sources 3 to 7 lands in its own read-only field
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         input4_result_ff         <= `AARC_RST_RES;
         usb_supply_result_ff     <= `AARC_RST_RES;
         adaptor_supply_result_ff <= `AARC_RST_RES;
         battery_result_ff        <= `AARC_RST_RES;
         die_temp_result_ff       <= `AARC_RST_RES;
      end else if (res_valid_in) begin
         case (res_src_in)
            `AARC_SRC_AUX4: begin
               input4_result_ff <= res_data_in;
            end
            `AARC_SRC_USB: begin
               usb_supply_result_ff <= res_data_in;
            end
            `AARC_SRC_LINE: begin
               adaptor_supply_result_ff <= res_data_in;
            end
            `AARC_SRC_BATT: begin
               battery_result_ff <= res_data_in;
            end
            `AARC_SRC_TEMP: begin
               die_temp_result_ff <= res_data_in;
            end
            default: begin
               // inputs 1 to 3 are held elsewhere
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // comparator control
   // ----------------------------------------------------------------
   // enables for all four, setup for comparator 1
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmp_en_ff             <= `AARC_RST_EN;
         cmp_one_source_ff     <= `AARC_RST_SRC;
         cmp_one_above_mode_ff <= `AARC_RST_ABOVE;
         cmp_one_threshold_ff  <= `AARC_RST_RES;
      end else begin
         if (wr_cmp_en) begin
            cmp_en_ff <= wr_data_in[NCMP-1:0];
         end
         if (wr_cmp1) begin
            cmp_one_source_ff <=
               wr_data_in[`AARC_SRC_MSB:`AARC_SRC_LSB];
            cmp_one_above_mode_ff <=
               wr_data_in[`AARC_ABOVE_BIT];
            cmp_one_threshold_ff <=
               wr_data_in[`AARC_RES_MSB:`AARC_RES_LSB];
         end
      end
   end

   // comparator 1 watches the live result stream
   aarc_cmp #(
      .RES_W        (RES_W)
   ) u_cmp_one (
      .enable_in    (cmp_en_ff[`AARC_CMP1_BIT]),
      .source_in    (cmp_one_source_ff),
      .above_in     (cmp_one_above_mode_ff),
      .threshold_in (cmp_one_threshold_ff),
      .res_valid_in (res_valid_in),
      .res_src_in   (res_src_in),
      .res_data_in  (res_data_in),
      .hit_out      (cmp_one_hit)
   );

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   // sticky flags, a new event wins over a same-cycle clear
   always @* begin
      evt = {NCMP{1'b0}};
      evt[`AARC_CMP1_BIT] = cmp_one_hit;
      clr = wr_clr ? wr_data_in[NCMP-1:0] : {NCMP{1'b0}};
      nxt_irq_stat = (irq_stat_ff & ~clr) | evt;
      nxt_irq_en = wr_irq_en ? wr_data_in[NCMP-1:0] : irq_en_ff;
   end

   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_stat_ff <= `AARC_RST_EN;
         irq_en_ff   <= `AARC_RST_EN;
         irq_out     <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_en_ff   <= nxt_irq_en;
         irq_out     <= |(nxt_irq_stat & nxt_irq_en);
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // unmapped and write-only addresses read as zero
   always @* begin
      nxt_rd_data = `AARC_RST_WORD;
      if (rd_en_in) begin
         case (addr_in)
            `AARC_OFS_AUX4: begin
               nxt_rd_data[`AARC_SCALE_MSB:`AARC_SCALE_LSB] = scale_ff;
               nxt_rd_data[`AARC_REF_BIT] = ref_ff;
               nxt_rd_data[`AARC_RES_MSB:`AARC_RES_LSB] =
                  input4_result_ff;
            end
            `AARC_OFS_USB: begin
               nxt_rd_data[`AARC_RES_MSB:`AARC_RES_LSB] =
                  usb_supply_result_ff;
            end
            `AARC_OFS_LINE: begin
               nxt_rd_data[`AARC_RES_MSB:`AARC_RES_LSB] =
                  adaptor_supply_result_ff;
            end
            `AARC_OFS_BATT: begin
               nxt_rd_data[`AARC_RES_MSB:`AARC_RES_LSB] =
                  battery_result_ff;
            end
            `AARC_OFS_TEMP: begin
               nxt_rd_data[`AARC_RES_MSB:`AARC_RES_LSB] =
                  die_temp_result_ff;
            end
            `AARC_OFS_CMP_EN: begin
               nxt_rd_data[NCMP-1:0] = cmp_en_ff;
            end
            `AARC_OFS_CMP1: begin
               nxt_rd_data[`AARC_SRC_MSB:`AARC_SRC_LSB] = cmp_one_source_ff;
               nxt_rd_data[`AARC_ABOVE_BIT] = cmp_one_above_mode_ff;
               nxt_rd_data[`AARC_RES_MSB:`AARC_RES_LSB] =
                  cmp_one_threshold_ff;
            end
            `AARC_OFS_IRQ_STAT: begin
               nxt_rd_data[NCMP-1:0] = irq_stat_ff;
            end
            `AARC_OFS_IRQ_EN: begin
               nxt_rd_data[NCMP-1:0] = irq_en_ff;
            end
            default: begin
               nxt_rd_data = `AARC_RST_WORD;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------
   // outputs mirror the control flops, read data lasts one cycle
   always @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out              <= `AARC_RST_WORD;
         input4_scale_sel_out     <= `AARC_RST_SCALE;
         input4_reference_sel_out <= `AARC_RST_REF;
         cmp_enables_out          <= `AARC_RST_EN;
      end else begin
         rd_data_out <= nxt_rd_data;
         input4_scale_sel_out <= wr_aux4 ?
            wr_data_in[`AARC_SCALE_MSB:`AARC_SCALE_LSB] : scale_ff;
         input4_reference_sel_out <= wr_aux4 ?
            wr_data_in[`AARC_REF_BIT] : ref_ff;
         cmp_enables_out <= wr_cmp_en ? wr_data_in[NCMP-1:0] : cmp_en_ff;
      end
   end

endmodule // aarc_top
`default_nettype wire

// ---- verification/aarc_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module aarc_checker (
   input wire logic        ref_clk_in,               // clock
   input wire logic        rst_n_in,                 // async reset, low
   input wire logic [7:0]  addr_in,                  // register address
   input wire logic [15:0] wr_data_in,               // write data
   input wire logic        wr_en_in,                 // write strobe
   input wire logic        rd_en_in,                 // read strobe
   input wire logic [15:0] rd_data_out,              // read data
   input wire logic        res_valid_in,             // result strobe
   input wire logic [2:0]  res_src_in,               // result source
   input wire logic [11:0] res_data_in,              // result value
   input wire logic [1:0]  input4_scale_sel_out,     // input 4 scaling
   input wire logic        input4_reference_sel_out, // input 4 reference
   input wire logic [3:0]  cmp_enables_out,          // comparator enables
   input wire logic        irq_out                   // level interrupt
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   sequence s_usb_store;
      res_valid_in && res_src_in == 3'h4;
   endsequence
   sequence s_usb_read;
      rd_en_in && addr_in == 8'h9c && !res_valid_in;
   endsequence
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   chk_scale_write: assert property (
      wr_en_in && addr_in == 8'h9b |=>
      input4_scale_sel_out == $past(wr_data_in[14:13]))
      else $error("scale field not taken");
   chk_scale_hold: assert property (
      !(wr_en_in && addr_in == 8'h9b) |=> $stable(input4_scale_sel_out))
      else $error("scale field changed without write");
   chk_ref_write: assert property (
      wr_en_in && addr_in == 8'h9b |=>
      input4_reference_sel_out == $past(wr_data_in[12]))
      else $error("reference select not taken");
   chk_en_write: assert property (
      wr_en_in && addr_in == 8'ha3 |=>
      cmp_enables_out == $past(wr_data_in[3:0]))
      else $error("enables not taken");
   chk_en_hold: assert property (
      !(wr_en_in && addr_in == 8'ha3) |=> $stable(cmp_enables_out))
      else $error("enables changed without write");
   chk_usb_readback: assert property (
      s_usb_store ##1 s_usb_read |=>
      rd_data_out == {4'h0, $past(res_data_in, 2)})
      else $error("usb result not read back");
   chk_result_upper: assert property (
      rd_en_in && addr_in >= 8'h9c && addr_in <= 8'h9f |=>
      rd_data_out[15:12] == 4'h0)
      else $error("result upper bits not zero");
   chk_rd_idle: assert property (
      !rd_en_in |=> rd_data_out == 16'h0000)
      else $error("read data outside read cycle");
   chk_irq_cause: assert property (
      $rose(irq_out) |-> $past(res_valid_in) || $past(wr_en_in, 2)
      || $past(res_valid_in, 2) || $past(wr_en_in))
      else $error("interrupt rose without cause");
endmodule // aarc_checker
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, wr_en_in = 1'b0;
   logic rd_en_in = 1'b0, res_valid_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [15:0] wr_data_in = 16'h0000;
   logic [2:0] res_src_in = 3'h0;
   logic [11:0] res_data_in = 12'h000;
   wire logic [15:0] rd_data_out;
   wire logic [1:0] input4_scale_sel_out;
   wire logic input4_reference_sel_out, irq_out;
   wire logic [3:0] cmp_enables_out;
   int mismatches = 0, num_checks = 0, cyc = 0;
   aarc_top i_aarc_top (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
      .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
      .res_valid_in(res_valid_in), .res_src_in(res_src_in),
      .res_data_in(res_data_in), .input4_scale_sel_out(input4_scale_sel_out),
      .input4_reference_sel_out(input4_reference_sel_out),
      .cmp_enables_out(cmp_enables_out), .irq_out(irq_out));
   // clock and hang guard
   initial forever #12.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches++;
         final_report;
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   // ------------------------------------------------------------
   // bus and result drivers
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      wr_en_in <= 1'b1; addr_in <= a; wr_data_in <= d;
      @(posedge ref_clk_in);
      wr_en_in <= 1'b0;
      @(posedge ref_clk_in); #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
      @(posedge ref_clk_in);
      rd_en_in <= 1'b1; addr_in <= a;
      @(posedge ref_clk_in);
      rd_en_in <= 1'b0; #1;
      chk(rd_data_out, exp);
   endtask
   task automatic res(input logic [2:0] s, input logic [11:0] d);
      @(posedge ref_clk_in);
      res_valid_in <= 1'b1; res_src_in <= s; res_data_in <= d;
      @(posedge ref_clk_in);
      res_valid_in <= 1'b0;
      @(posedge ref_clk_in); #1;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk({14'h0, input4_scale_sel_out}, 16'h0003);
      chk({15'h0, input4_reference_sel_out}, 16'h0001);
      chk({12'h0, cmp_enables_out}, 16'h0000);
      rdc(8'h9b, 16'h7000);
      for (int i = 0; i < 4; i++) rdc(8'h9c + 8'(i), 16'h0000);
      rdc(8'ha4, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_aux4;
      for (int i = 0; i < 4; i++) begin
         wr(8'h9b, {1'b1, 2'(i), 1'b0, 12'hfff});
         chk({14'h0, input4_scale_sel_out}, 16'(i));
         chk({15'h0, input4_reference_sel_out}, 16'h0000);
         rdc(8'h9b, {1'b0, 2'(i), 13'h0000});
      end
      wr(8'h9b, 16'h3000);
      res(3'h3, 12'hfff);
      rdc(8'h9b, 16'h3fff);
      res(3'h0, 12'h123);
      rdc(8'h9b, 16'h3fff);
      $display("test input4 done");
   endtask
   task automatic t_results;
      for (int i = 0; i < 4; i++) begin
         logic [7:0] a;
         a = 8'h9c + 8'(i);
         res(3'h4 + 3'(i), 12'ha50 + 12'(i));
         wr(a, 16'hffff);
         rdc(a, 16'ha50 + 16'(i));
      end
      // result strobe then read with no gap
      @(posedge ref_clk_in);
      res_valid_in <= 1'b1; res_src_in <= 3'h4; res_data_in <= 12'h9e1;
      @(posedge ref_clk_in);
      res_valid_in <= 1'b0; rd_en_in <= 1'b1; addr_in <= 8'h9c;
      @(posedge ref_clk_in);
      rd_en_in <= 1'b0; #1;
      chk(rd_data_out, 16'h09e1);
      rdc(8'h00, 16'h0000);
      $display("test results done");
   endtask
   task automatic t_cmp;
      wr(8'ha3, 16'hfff5);
      chk({12'h0, cmp_enables_out}, 16'h0005);
      rdc(8'ha3, 16'h0005);
      for (int i = 0; i < 8; i++) begin
         logic [15:0] w;
         w = {3'(i), 1'(i), 12'h5a5 + 12'(i)};
         wr(8'ha4, w);
         rdc(8'ha4, w);
      end
      wr(8'hb2, 16'h0001);
      wr(8'ha3, 16'h0001);
      wr(8'ha4, {3'h4, 1'b1, 12'h7ff});
      res(3'h4, 12'h7ff);
      chk({15'h0, irq_out}, 16'h0000);
      res(3'h4, 12'h800);
      chk({15'h0, irq_out}, 16'h0001);
      rdc(8'hb0, 16'h0001);
      wr(8'hb1, 16'h0001);
      chk({15'h0, irq_out}, 16'h0000);
      res(3'h5, 12'hfff);
      chk({15'h0, irq_out}, 16'h0000);
      wr(8'ha4, {3'h6, 1'b0, 12'h100});
      res(3'h6, 12'h0ff);
      chk({15'h0, irq_out}, 16'h0001);
      wr(8'hb2, 16'h0000);
      chk({15'h0, irq_out}, 16'h0000);
      wr(8'hb1, 16'h0001);
      wr(8'hb2, 16'h0001);
      wr(8'ha3, 16'h0000);
      res(3'h6, 12'h0ff);
      chk({15'h0, irq_out}, 16'h0000);
      rdc(8'hb0, 16'h0000);
      $display("test comparator done");
   endtask
   // unstored source, event against clear, reset in mid-run
   task automatic t_late;
      wr(8'h9b, 16'h4000);
      wr(8'ha3, 16'h0001);
      wr(8'ha4, {3'h1, 1'b1, 12'h100});
      res(3'h1, 12'h200);
      chk({15'h0, irq_out}, 16'h0001);
      rdc(8'h9b, 16'h4fff);
      // event and clear in one cycle, the event wins
      @(posedge ref_clk_in);
      wr_en_in <= 1'b1; addr_in <= 8'hb1; wr_data_in <= 16'h0001;
      res_valid_in <= 1'b1; res_src_in <= 3'h1; res_data_in <= 12'h300;
      @(posedge ref_clk_in);
      wr_en_in <= 1'b0; res_valid_in <= 1'b0;
      @(posedge ref_clk_in); #1;
      chk({15'h0, irq_out}, 16'h0001);
      rdc(8'hb0, 16'h0001);
      // second reset while control state is non-default
      @(posedge ref_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(posedge ref_clk_in); #1;
      chk({14'h0, input4_scale_sel_out}, 16'h0003);
      chk({15'h0, input4_reference_sel_out}, 16'h0001);
      chk({12'h0, cmp_enables_out}, 16'h0000);
      chk({15'h0, irq_out}, 16'h0000);
      rdc(8'h9b, 16'h7000);
      rdc(8'ha4, 16'h0000);
      rdc(8'h9e, 16'h0000);
      rdc(8'hb0, 16'h0000);
      $display("test late done");
   endtask
   initial begin
      repeat (6) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(posedge ref_clk_in); #1;
      t_reset;
      t_aux4;
      t_results;
      t_cmp;
      t_late;
      final_report;
   end
endmodule // tb
bind aarc_top aarc_checker i_aarc_checker (.ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
   .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .rd_data_out(rd_data_out),
   .res_valid_in(res_valid_in), .res_src_in(res_src_in),
   .res_data_in(res_data_in), .input4_scale_sel_out(input4_scale_sel_out),
   .input4_reference_sel_out(input4_reference_sel_out),
   .cmp_enables_out(cmp_enables_out), .irq_out(irq_out));
`default_nettype wire
